// *** rtl/twm_timer.v ***
/*
 * Sixteen-bit timer with waveform mode control, two compare channels,
 * force-compare strobes, pin override and a small interrupt unit.
 * Assumes a classic Wishbone master on the 10 MHz clk_i, and port logic
 * that supplies each pin's direction bit and ordinary port data.
 */
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
// Function
// - A nonzero output-mode field lets the channel output take over the pin.
// - The channel output drives the pin only when its direction bit is output.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match, set at BOTTOM; 11 the inverse.
// - Fast PWM 01: channel A toggles only in mode 15, B disconnected.
// - Fast PWM: match at TOP ignored when upper bit set; BOTTOM action kept.
// - Dual slope: 10 clears up-counting, sets down-counting; 11 the reverse.
// - Dual slope 01: channel A toggles only in mode 9, B disconnected.
// - In non-PWM modes a force strobe applies an immediate match action.
// - A force strobe sets no flag and never resets the counter.
// - Force bits are write-only strobes and read as zero.
// - Four-bit mode joins two low bits here and two high bits elsewhere.
// - Modes 0, 4, 12: TOP max/A/capture, immediate update, flag at MAX.
// - Modes 1-3, 10, 11: phase correct, update at TOP, flag at BOTTOM.
// - Modes 5-7, 14, 15: fast PWM, update at BOTTOM, flag at TOP.
// - Modes 8, 9: TOP capture/A, update and flag at BOTTOM.
`timescale 1ns/1ps
`default_nettype none
`include "twm_defines.vh"

module twm_timer #(
  parameter PRESCALE = 1
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  // Port logic for channel A pin.
  input wire port_dir_a_i,
  input wire port_data_a_i,
  input wire pin_a_i,
  output wire pin_a_o,
  output wire pin_a_oe_n_o,
  // Port logic for channel B pin.
  input wire port_dir_b_i,
  input wire port_data_b_i,
  input wire pin_b_i,
  output wire pin_b_o,
  output wire pin_b_oe_n_o,
  // Interrupt.
  output wire irq_o
);

  reg [7:0] ctla_reg;
  reg [7:0] ctlb_reg;
  reg [15:0] cmpa_buf_reg;
  reg [15:0] cmpb_buf_reg;
  reg [15:0] cmpa_reg;
  reg [15:0] cmpb_reg;
  reg [15:0] capt_reg;
  reg [15:0] cnt_reg;
  reg down_reg;
  reg wave_a_reg;
  reg wave_b_reg;
  reg [2:0] stat_reg;
  reg [2:0] ien_reg;
  reg [31:0] dat_reg;
  reg ack_reg;
  reg pin_a_reg;
  reg pin_a_oe_n_reg;
  reg pin_b_reg;
  reg pin_b_oe_n_reg;
  reg [15:0] div_reg;
  reg tick_reg;

  wire [3:0] mode;
  wire [15:0] top;
  wire is_fast;
  wire is_dual;
  wire is_nonpwm;
  wire upd_at_top;
  wire at_top;
  wire at_bottom;
  wire match_a;
  wire match_b;
  wire ovf_evt;
  wire wr_req;
  wire conn_a;
  wire conn_b;
  wire force_a;
  wire force_b;
  wire [1:0] com_a;
  wire [1:0] com_b;

  // Merge a 16-bit register with the low two byte lanes of a write.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] sel;
    begin
      merge16[7:0] = sel[0] ? data[7:0] : old[7:0];
      merge16[15:8] = sel[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // TOP value selected by the waveform mode.
  function [15:0] top_of;
    input [3:0] m;
    input [15:0] cmp_a;
    input [15:0] capt;
    begin
      case (m)
        4'h1, 4'h5: top_of = `TWM_TOP_8;
        4'h2, 4'h6: top_of = `TWM_TOP_9;
        4'h3, 4'h7: top_of = `TWM_TOP_10;
        `TWM_MODE_CTC_CMP, 4'h9, 4'hB, `TWM_MODE_FAST_CMP: begin
          top_of = cmp_a;
        end
        4'h8, 4'hA, `TWM_MODE_CTC_CAP, `TWM_MODE_FAST_CAP: begin
          top_of = capt;
        end
        default: top_of = `TWM_TOP_MAX;
      endcase
    end
  endfunction

  // Whether channel A may toggle under encoding 01 in a PWM mode.
  function toggle_ok;
    input [3:0] m;
    input fast;
    begin
      toggle_ok = (fast && m == `TWM_MODE_FAST_CMP) ||
        (!fast && (m == `TWM_MODE_PFC_CMP || m == `TWM_MODE_FAST_CAP));
    end
  endfunction

  // Mode decode; the mode is split across the two control registers.
  assign mode = {ctlb_reg[`TWM_CB_WGM_HI:`TWM_CB_WGM_LO],
                 ctla_reg[`TWM_CA_WGM_HI:`TWM_CA_WGM_LO]};
  assign top = top_of(mode, cmpa_reg, capt_reg);
  assign is_fast = (mode >= 4'h5 && mode <= 4'h7) || mode >= 4'hE;
  assign is_dual = (mode >= 4'h1 && mode <= 4'h3) ||
                   (mode >= 4'h8 && mode <= 4'hB);
  assign is_nonpwm = !is_fast && !is_dual && mode != `TWM_MODE_RSVD;
  assign upd_at_top = (mode >= 4'h1 && mode <= 4'h3) || mode == 4'hA ||
                      mode == 4'hB;
  assign com_a = ctla_reg[`TWM_CA_MODE_A_HI:`TWM_CA_MODE_A_LO];
  assign com_b = ctla_reg[`TWM_CA_MODE_B_HI:`TWM_CA_MODE_B_LO];

  // Count events, qualified by the timer enable.
  assign at_top = tick_reg && cnt_reg == top;
  assign at_bottom = tick_reg && cnt_reg == 16'h0000;
  assign match_a = tick_reg && cnt_reg == cmpa_reg;
  assign match_b = tick_reg && cnt_reg == cmpb_reg;
  assign ovf_evt = is_fast ? at_top :
                   is_dual ? (at_bottom && down_reg) :
                   (tick_reg && cnt_reg == `TWM_TOP_MAX);

  // Bus decode; a request is taken once, in the cycle before ack.
  assign wr_req = cyc_i && stb_i && we_i && !ack_reg;
  assign force_a = wr_req && adr_i == `TWM_OFS_CTLA && sel_i[0] &&
                   dat_i[`TWM_CA_FORCE_A] && is_nonpwm;
  assign force_b = wr_req && adr_i == `TWM_OFS_CTLA && sel_i[0] &&
                   dat_i[`TWM_CA_FORCE_B] && is_nonpwm;

  // Pin ownership: encoding 01 in PWM modes leaves the pin to the port, except channel A in modes 9 and 15.
  assign conn_a = com_a != `TWM_COM_OFF && (is_nonpwm ||
                  com_a != `TWM_COM_TOGGLE || toggle_ok(mode, is_fast));
  assign conn_b = com_b != `TWM_COM_OFF && (is_nonpwm ||
                  com_b != `TWM_COM_TOGGLE);

  // Timer enable divider; the slower rate is a one-cycle pulse.
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (!ctlb_reg[`TWM_CB_RUN]) begin
      div_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (div_reg == PRESCALE[15:0] - 16'h0001) begin
      div_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // Control, compare and capture registers; a software write to the
  // counter wins over counting in the same cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctla_reg <= `TWM_RST_CTL;
      ctlb_reg <= `TWM_RST_CTL;
      cmpa_buf_reg <= `TWM_RST_WORD;
      cmpb_buf_reg <= `TWM_RST_WORD;
      capt_reg <= `TWM_RST_WORD;
      ien_reg <= `TWM_RST_IRQ;
    end else if (wr_req) begin
      case (adr_i)
        `TWM_OFS_CTLA: begin
          if (sel_i[0]) begin
            ctla_reg <= dat_i[7:0] & 8'hF3;
          end
        end
        `TWM_OFS_CTLB: begin
          if (sel_i[0]) begin
            ctlb_reg <= dat_i[7:0] & 8'h19;
          end
        end
        `TWM_OFS_CMPA: cmpa_buf_reg <= merge16(cmpa_buf_reg, dat_i, sel_i);
        `TWM_OFS_CMPB: cmpb_buf_reg <= merge16(cmpb_buf_reg, dat_i, sel_i);
        `TWM_OFS_CAPT: capt_reg <= merge16(capt_reg, dat_i, sel_i);
        `TWM_OFS_IEN: begin
          if (sel_i[0]) begin
            ien_reg <= dat_i[2:0];
          end
        end
        default: ctla_reg <= ctla_reg;
      endcase
    end
  end

  // Active compare values: immediate in non-PWM modes, otherwise loaded
  // from the buffer at TOP or BOTTOM so a period is never torn.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmpa_reg <= `TWM_RST_WORD;
      cmpb_reg <= `TWM_RST_WORD;
    end else if (!is_fast && !is_dual) begin
      cmpa_reg <= cmpa_buf_reg;
      cmpb_reg <= cmpb_buf_reg;
    end else if (upd_at_top ? at_top : at_bottom) begin
      cmpa_reg <= cmpa_buf_reg;
      cmpb_reg <= cmpb_buf_reg;
    end
  end

  // Counter: single slope wraps at TOP, dual slope turns at both ends.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= `TWM_RST_WORD;
      down_reg <= 1'b0;
    end else if (wr_req && adr_i == `TWM_OFS_CNT) begin
      cnt_reg <= merge16(cnt_reg, dat_i, sel_i);
    end else if (tick_reg) begin
      if (is_dual) begin
        if (!down_reg && cnt_reg >= top) begin
          down_reg <= 1'b1;
          cnt_reg <= cnt_reg - 16'h0001;
        end else if (down_reg && cnt_reg == 16'h0000) begin
          down_reg <= 1'b0;
          cnt_reg <= 16'h0001;
        end else if (down_reg) begin
          cnt_reg <= cnt_reg - 16'h0001;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end else begin
        down_reg <= 1'b0;
        // Only real TOP matches clear the count, never a force.
        cnt_reg <= at_top ? 16'h0000 : cnt_reg + 16'h0001;
      end
    end
  end

  // Waveform units, one per channel.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
    end else if (is_nonpwm) begin
      if (match_a || force_a) begin
        case (com_a)
          `TWM_COM_TOGGLE: wave_a_reg <= !wave_a_reg;
          `TWM_COM_CLEAR: wave_a_reg <= 1'b0;
          `TWM_COM_SET: wave_a_reg <= 1'b1;
          default: wave_a_reg <= wave_a_reg;
        endcase
      end
      if (match_b || force_b) begin
        case (com_b)
          `TWM_COM_TOGGLE: wave_b_reg <= !wave_b_reg;
          `TWM_COM_CLEAR: wave_b_reg <= 1'b0;
          `TWM_COM_SET: wave_b_reg <= 1'b1;
          default: wave_b_reg <= wave_b_reg;
        endcase
      end
    end else if (is_fast) begin
      // BOTTOM action applies as the count wraps; a match at TOP with the
      // upper bit set is dropped so the output does not glitch.
      if (at_top && com_a[1]) begin
        wave_a_reg <= !com_a[0];
      end else if (match_a && com_a[1]) begin
        wave_a_reg <= com_a[0];
      end else if (match_a && com_a == `TWM_COM_TOGGLE &&
                   toggle_ok(mode, 1'b1)) begin
        wave_a_reg <= !wave_a_reg;
      end
      if (at_top && com_b[1]) begin
        wave_b_reg <= !com_b[0];
      end else if (match_b && com_b[1]) begin
        wave_b_reg <= com_b[0];
      end
    end else if (is_dual) begin
      if (match_a && com_a[1]) begin
        wave_a_reg <= com_a[0] ^ down_reg;
      end else if (match_a && com_a == `TWM_COM_TOGGLE &&
                   toggle_ok(mode, 1'b0)) begin
        wave_a_reg <= !wave_a_reg;
      end
      if (match_b && com_b[1]) begin
        wave_b_reg <= com_b[0] ^ down_reg;
      end
    end
  end

  // Interrupt status: hardware set wins over a same-cycle clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= `TWM_RST_IRQ;
    end else begin
      stat_reg <= (stat_reg & ~((wr_req && adr_i == `TWM_OFS_ICLR &&
                  sel_i[0]) ? dat_i[2:0] : 3'h0)) |
                  {match_b, match_a, ovf_evt};
    end
  end

  // Pin drivers: the override needs both a connected channel and an
  // output direction bit, otherwise the port keeps the pin.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_reg <= 1'b0;
      pin_a_oe_n_reg <= 1'b1;
      pin_b_reg <= 1'b0;
      pin_b_oe_n_reg <= 1'b1;
    end else begin
      pin_a_reg <= conn_a ? wave_a_reg : port_data_a_i;
      pin_a_oe_n_reg <= !port_dir_a_i;
      pin_b_reg <= conn_b ? wave_b_reg : port_data_b_i;
      pin_b_oe_n_reg <= !port_dir_b_i;
    end
  end

  // Bus answer one cycle after the request; unmapped reads return zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= cyc_i && stb_i && !ack_reg;
      case (adr_i)
        `TWM_OFS_CTLA: dat_reg <= {24'h000000, ctla_reg};
        `TWM_OFS_CTLB: dat_reg <= {24'h000000, ctlb_reg};
        `TWM_OFS_CMPA: dat_reg <= {16'h0000, cmpa_buf_reg};
        `TWM_OFS_CMPB: dat_reg <= {16'h0000, cmpb_buf_reg};
        `TWM_OFS_CAPT: dat_reg <= {16'h0000, capt_reg};
        `TWM_OFS_CNT: dat_reg <= {15'h0000, down_reg, cnt_reg};
        `TWM_OFS_STAT: dat_reg <= {29'h00000000, stat_reg};
        `TWM_OFS_IEN: dat_reg <= {29'h00000000, ien_reg};
        `TWM_OFS_PINS: begin
          dat_reg <= {24'h000000, conn_b, conn_a, pin_b_i, pin_a_i,
                      port_dir_b_i, port_dir_a_i, wave_b_reg, wave_a_reg};
        end
        default: dat_reg <= 32'h00000000;
      endcase
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign pin_a_o = pin_a_reg;
  assign pin_a_oe_n_o = pin_a_oe_n_reg;
  assign pin_b_o = pin_b_reg;
  assign pin_b_oe_n_o = pin_b_oe_n_reg;
  assign irq_o = |(stat_reg & ien_reg);

endmodule
`default_nettype wire

// *** rtl/twm_defines.vh ***
/*
 * Constants for the timer waveform and mode controller: register byte
 * offsets, field positions, reset values, mode codes and fixed TOP values.
 * Assumes it is included by bare name from the design file.
 */
`ifndef TWM_DEFINES_VH
`define TWM_DEFINES_VH

// Register byte offsets on the Wishbone bus.
`define TWM_OFS_CTLA 8'h00
`define TWM_OFS_CTLB 8'h04
`define TWM_OFS_CMPA 8'h08
`define TWM_OFS_CMPB 8'h0C
`define TWM_OFS_CAPT 8'h10
`define TWM_OFS_CNT 8'h14
`define TWM_OFS_STAT 8'h18
`define TWM_OFS_ICLR 8'h1C
`define TWM_OFS_IEN 8'h20
`define TWM_OFS_PINS 8'h24

// Field positions in waveform_control_a.
`define TWM_CA_MODE_A_HI 7
`define TWM_CA_MODE_A_LO 6
`define TWM_CA_MODE_B_HI 5
`define TWM_CA_MODE_B_LO 4
`define TWM_CA_FORCE_A 3
`define TWM_CA_FORCE_B 2
`define TWM_CA_WGM_HI 1
`define TWM_CA_WGM_LO 0

// Field positions in waveform_control_b.
`define TWM_CB_WGM_HI 4
`define TWM_CB_WGM_LO 3
`define TWM_CB_RUN 0

// Interrupt status bit positions.
`define TWM_IRQ_OVF 0
`define TWM_IRQ_MATCH_A 1
`define TWM_IRQ_MATCH_B 2

// Reset values.
`define TWM_RST_CTL 8'h00
`define TWM_RST_WORD 16'h0000
`define TWM_RST_IRQ 3'h0

// Waveform mode codes.
`define TWM_MODE_NORMAL 4'h0
`define TWM_MODE_CTC_CMP 4'h4
`define TWM_MODE_PFC_CMP 4'h9
`define TWM_MODE_CTC_CAP 4'hC
`define TWM_MODE_RSVD 4'hD
`define TWM_MODE_FAST_CAP 4'hE
`define TWM_MODE_FAST_CMP 4'hF

// Fixed TOP values.
`define TWM_TOP_MAX 16'hFFFF
`define TWM_TOP_8 16'h00FF
`define TWM_TOP_9 16'h01FF
`define TWM_TOP_10 16'h03FF

// Output-mode encodings.
`define TWM_COM_OFF 2'h0
`define TWM_COM_TOGGLE 2'h1
`define TWM_COM_CLEAR 2'h2
`define TWM_COM_SET 2'h3

`endif

// *** tb/twm_timer_chk.sv ***
/* Checker for the timer waveform block: bus handshake, pin hand-over and
   force strobe relations. Assumes it is bound to twm_timer and sees only
   that module's ports. */
`timescale 1ns/1ps
`default_nettype none
`include "twm_defines.vh"
module twm_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins and interrupt.
  input wire logic port_dir_a_i,
  input wire logic port_data_a_i,
  input wire logic port_data_b_i,
  input wire logic pin_a_o,
  input wire logic pin_a_oe_n_o,
  input wire logic pin_b_o,
  input wire logic irq_o
);
  logic [3:0] wgm_reg;
  logic [1:0] ma_reg;
  logic [1:0] mb_reg;
  logic run_reg;
  wire take = cyc_i && stb_i && we_i && !ack_o;
  wire frc_a = take && adr_i == `TWM_OFS_CTLA && dat_i[3] && !run_reg
    && dat_i[7:6] == ma_reg;
  wire nonpwm = wgm_reg == 4'h0 || wgm_reg == 4'h4 || wgm_reg == 4'hC;
  wire pwm = !nonpwm && wgm_reg != `TWM_MODE_RSVD;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow the mode fields so that pin relations know the setting in force.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {wgm_reg, ma_reg, mb_reg, run_reg} <= 9'h000;
    end else if (take && adr_i == `TWM_OFS_CTLA) begin
      {ma_reg, mb_reg} <= dat_i[7:4];
      wgm_reg[1:0] <= dat_i[1:0];
    end else if (take && adr_i == `TWM_OFS_CTLB) begin
      wgm_reg[3:2] <= dat_i[4:3];
      run_reg <= dat_i[0];
    end
  end
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_force_read_zero: assert property (
    ack_o && !we_i && adr_i == `TWM_OFS_CTLA |-> dat_o[3:2] == 2'h0)
    else $error("force bits read back nonzero");
  a_dir_drives: assert property (port_dir_a_i |=> !pin_a_oe_n_o)
    else $error("pin driver off with direction output");
  a_dir_floats: assert property (!port_dir_a_i |=> pin_a_oe_n_o)
    else $error("pin driver on with direction input");
  a_idle_port_a: assert property (
    ma_reg == 2'h0 |=> pin_a_o == $past(port_data_a_i))
    else $error("channel A pin not under port control");
  a_idle_port_b: assert property (
    mb_reg == 2'h0 || (mb_reg == 2'h1 && pwm)
    |=> pin_b_o == $past(port_data_b_i))
    else $error("channel B pin not under port control");
  a_force_level: assert property (
    frc_a && nonpwm && ma_reg[1] |-> ##2 pin_a_o == $past(dat_i[6], 2))
    else $error("forced set or clear missed");
  a_force_toggle: assert property (
    frc_a && nonpwm && ma_reg == 2'h1 |-> ##2 pin_a_o != $past(pin_a_o))
    else $error("forced toggle missed");
  a_pwm_no_force: assert property (
    frc_a && pwm && ma_reg[1] |-> ##2 $stable(pin_a_o))
    else $error("force acted in a PWM mode");
  a_force_no_irq: assert property (frc_a && !irq_o |=> !irq_o [*3])
    else $error("force strobe raised the interrupt");
endmodule
bind twm_timer twm_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .port_dir_a_i(port_dir_a_i),
  .port_data_a_i(port_data_a_i), .port_data_b_i(port_data_b_i),
  .pin_a_o(pin_a_o), .pin_a_oe_n_o(pin_a_oe_n_o), .pin_b_o(pin_b_o),
  .irq_o(irq_o));
`default_nettype wire

// *** tb/twm_port_model.sv ***
/* Port logic beside the timer pins: direction and data registers and the
   resulting pin levels. Assumes the bench sets the port registers. */
`timescale 1ns/1ps
`default_nettype none
module twm_port_model (
  // Clock and register requests.
  input wire logic clk_i,
  input wire logic [1:0] dir_req_i,
  input wire logic [1:0] data_req_i,
  // Timer pin drivers, bit 0 channel A and bit 1 channel B.
  input wire logic [1:0] drv_i,
  input wire logic [1:0] oe_n_i,
  // Port registers and pin levels.
  output logic [1:0] dir_o,
  output logic [1:0] data_o,
  output var logic [1:0] level_o = 2'h0
);
  // Port registers follow software at once.
  assign dir_o = dir_req_i;
  assign data_o = data_req_i;
  logic [1:0] last_drv = 2'h0;
  // A released pin has no pull, so it shows the inverse of the last driven
  // level; a design that reads a floating pin then sees a wrong value.
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (!oe_n_i[i]) begin
        last_drv[i] <= drv_i[i];
        level_o[i] <= drv_i[i];
      end else begin
        level_o[i] <= ~last_drv[i];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/twm_timer_tb.sv ***
/* Self-checking bench for twm_timer: register access, pin hand-over,
   force strobes, PWM duty and interrupt. Assumes the port model file. */
`timescale 1ns/1ps
`default_nettype none
`include "twm_defines.vh"
module twm_timer_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, irq_o;
  logic [1:0] dir_req = 2'h0, data_req = 2'h0, dir, pdata, level, drv, oe_n;
  logic [31:0] exp_q[$];
  int fail_count = 0, checked = 0, hi;
  twm_timer u_twm_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .port_dir_a_i(dir[0]),
    .port_data_a_i(pdata[0]), .pin_a_i(level[0]), .pin_a_o(drv[0]),
    .pin_a_oe_n_o(oe_n[0]), .port_dir_b_i(dir[1]), .port_data_b_i(pdata[1]),
    .pin_b_i(level[1]), .pin_b_o(drv[1]), .pin_b_oe_n_o(oe_n[1]),
    .irq_o(irq_o));
  twm_port_model u_twm_port_model (.clk_i(clk_i), .dir_req_i(dir_req),
    .data_req_i(data_req), .drv_i(drv), .oe_n_i(oe_n), .dir_o(dir),
    .data_o(pdata), .level_o(level));
  // Free-running 10 MHz clock.
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic s);
    chk_word(nm, {31'h0, e}, {31'h0, s});
  endtask
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One classic cycle; the request holds until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Read data is judged against the oldest note at the acknowledging edge.
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      chk_word("read", exp_q.pop_front(), dat_o);
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #4000000;
    fail_count++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    logic [1:0] mt[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic [7:0] hb[3] = '{8'h00, 8'h08, 8'h18};
    logic [31:0] cf[7] = '{32'h0981_0080, 32'h0981_00FF, 32'h09C1_0080,
                           32'h0181_0080, 32'h01C1_0080, 32'h1943_007F,
                           32'h1141_0040};
    logic [31:0] ex[7] = '{32'h0100_0081, 32'h0100_0100, 32'h0100_007F,
                           32'h01FE_0100, 32'h01FE_00FE, 32'h0100_0080,
                           32'h0100_0080};
    void'($urandom(32'hc500));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TWM_OFS_CTLA, 32'h0);
    rd(8'hFC, 32'h0);
    // Random settings read back with the strobes gone.
    repeat (4) begin
      r = $urandom() & 32'hFF;
      if (r[1:0] != 2'h0 || hi != 0) r[3:2] = 2'h0;
      wb(1'b1, `TWM_OFS_CTLA, r);
      hi = r[1:0];
      rd(`TWM_OFS_CTLA, r & 32'hF3);
    end
    // Outputs off: port data and direction reach the pins unchanged.
    wb(1'b1, `TWM_OFS_CTLA, 32'h0);
    repeat (4) begin
      data_req <= 2'($urandom());
      dir_req <= 2'($urandom());
      repeat (2) @(posedge clk_i);
      chk_word("port", {30'h0, data_req}, {30'h0, drv});
      chk_word("oe_n", {30'h0, ~dir_req}, {30'h0, oe_n});
    end
    dir_req <= 2'h3;
    // PWM duty over one period for each table entry, overflow enabled.
    // The count restarts from zero so that a lower TOP is never overrun.
    wb(1'b1, `TWM_OFS_IEN, 32'h1);
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, `TWM_OFS_CTLB, 32'h0);
      wb(1'b1, `TWM_OFS_CNT, 32'h0);
      wb(1'b1, `TWM_OFS_CTLA, {24'h0, cf[i][23:16]});
      wb(1'b1, `TWM_OFS_CMPA, {16'h0, cf[i][15:0]});
      wb(1'b1, `TWM_OFS_CTLB, {24'h0, cf[i][31:24]});
      repeat (1600) @(posedge clk_i);
      hi = 0;
      repeat (ex[i][31:16]) begin
        @(posedge clk_i);
        hi += drv[0];
      end
      chk_word("duty", {16'h0, ex[i][15:0]}, hi);
    end
    wb(1'b1, `TWM_OFS_CTLB, 32'h0);
    chk_bit("irq", 1'b1, irq_o);
    wb(1'b1, `TWM_OFS_IEN, 32'h0);
    chk_bit("irq", 1'b0, irq_o);
    wb(1'b1, `TWM_OFS_IEN, 32'h1);
    chk_bit("irq", 1'b1, irq_o);
    wb(1'b1, `TWM_OFS_ICLR, 32'h7);
    chk_bit("irq", 1'b0, irq_o);
    // A force in a PWM mode leaves the pin alone.
    r = {31'h0, drv[0]};
    wb(1'b1, `TWM_OFS_CTLA, 32'hC9);
    repeat (2) @(posedge clk_i);
    chk_bit("pin_a", r[0], drv[0]);
    // Forces in modes 0, 4 and 12 with every action, interrupts enabled.
    wb(1'b1, `TWM_OFS_IEN, 32'h7);
    foreach (hb[j]) begin
      wb(1'b1, `TWM_OFS_CTLB, {24'h0, hb[j]});
      for (int i = 0; i < 4; i++) begin
        wb(1'b1, `TWM_OFS_CTLA, {24'h0, mt[i], 6'h00});
        wb(1'b1, `TWM_OFS_CTLA, {24'h0, mt[i], 6'h08});
        repeat (2) @(posedge clk_i);
        chk_bit("pin_a", i % 2 == 0, drv[0]);
        chk_bit("irq", 1'b0, irq_o);
      end
    end
    // Channel B forced low while channel A hands its pin back to the port.
    wb(1'b1, `TWM_OFS_CTLA, 32'h20);
    wb(1'b1, `TWM_OFS_CTLA, 32'h24);
    rd(`TWM_OFS_PINS, {24'h0, 3'h4, data_req[0], 4'hC});
    summarize();
  end
endmodule
`default_nettype wire
